// File: rtl/simwd_pkg.sv
// Package for the integration-module watchdog, stop, pin-select and park registers.
package simwd_pkg;

  // Register byte offsets from the module base.
  localparam logic [7:0] SIMWD_OFF_WD_VECTOR  = 8'h02;
  localparam logic [7:0] SIMWD_OFF_PIN_SELECT = 8'h04;
  localparam logic [7:0] SIMWD_OFF_PARK       = 8'h0C;
  localparam logic [7:0] SIMWD_OFF_WD_SERVICE = 8'h03;
  localparam logic [7:0] SIMWD_OFF_CLK_CTRL   = 8'h08;

  // Reset values.
  localparam logic [7:0]  SIMWD_RST_WD_VECTOR = 8'h0F;
  localparam logic [7:0]  SIMWD_RST_PARK      = 8'h00;
  localparam logic [15:0] SIMWD_PIN_ALL_PP    = 16'h0000;
  localparam logic [15:0] SIMWD_PIN_ALL_ALT   = 16'hFFFF;

  // Service sequence key values.
  localparam logic [7:0] SIMWD_KEY_FIRST  = 8'h55;
  localparam logic [7:0] SIMWD_KEY_SECOND = 8'hAA;

  // Wake threshold special codes.
  localparam logic [2:0] SIMWD_WAKE_ANY  = 3'h0;
  localparam logic [2:0] SIMWD_WAKE_NONE = 3'h7;

  // Park register field positions.
  localparam int SIMWD_PARK_HI   = 7;
  localparam int SIMWD_PARK_LO   = 6;
  localparam int SIMWD_IARB_BIT  = 5;
  localparam int SIMWD_EARB_BIT  = 4;
  localparam int SIMWD_SHOW_BIT  = 3;
  localparam int SIMWD_WIDTH_BIT = 0;
  localparam logic [7:0] SIMWD_PARK_MASK = 8'hF9;

  // Clock control register field positions (stop enable, wake threshold).
  localparam int SIMWD_STOPEN_BIT = 3;
  localparam int SIMWD_WAKE_HI    = 2;
  localparam int SIMWD_WAKE_LO    = 0;

  // Park arbitration encodings.
  typedef enum logic [1:0] {
    SIMWD_ROUND_ROBIN,
    SIMWD_PARK_CORE,
    SIMWD_PARK_DMA,
    SIMWD_PARK_CURRENT
  } simwd_park_t;

  // Service sequence state.
  typedef enum logic {
    SIMWD_SVC_IDLE,
    SIMWD_SVC_ARMED
  } simwd_svc_t;

  // Register bus request carrier.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } simwd_bus_t;

  // Whole block state.
  typedef struct packed {
    logic [7:0]  wd_vector;
    logic [15:0] pin_select;
    logic [7:0]  park;
    logic        stop_enable;
    logic [2:0]  wake_threshold;
    simwd_svc_t  svc;
    logic        pending;
    logic        service_pulse;
    logic        core_clk_gated;
    logic        stop_ack;
    logic        wake;
    logic [15:0] rdata;
    logic [7:0]  interrupt_ack_cycle_vector;
    logic        interrupt_ack_cycle_valid;
    logic        rst_seen;
    logic        show;
  } simwd_state_t;

endpackage : simwd_pkg

// File: rtl/simwd_regs.sv
// Watchdog vector/service, stop gating, pin select and bus park registers.
// Functional notes
// - Hold 8-bit watchdog vector, return it during the watchdog acknowledge cycle; the code returns it registered, one cycle after the acknowledge.
// - Reset loads the watchdog vector register with 0x0F.
// - Watchdog acknowledge always returns the programmed vector, never an autovector.
// - Service happens only after 0x55 then 0xAA written to service register.
// - Unrelated accesses between the two service writes do not abort sequence.
// - Service writes after timeout do not clear the pending watchdog flag.
// - Watchdog acknowledge cycle clears the pending flag automatically.
// - Stop requests are acknowledged only while stop enable is set.
// - Stop enable resets to zero, so stop is refused until set.
// - Acknowledged stop gates only core clocks; other modules keep running.
// - Wake threshold: 000 any level, 111 none, else levels above code wake.
// - Qualifying interrupt restores core clocks, then exception processing proceeds.
// - Each pin select bit picks parallel port bit or alternate pin function.
// - At reset release, all pin select bits copy the configuration strap level.
// - Park register is 8-bit read/write, reset zero, with its documented fields.
// - Park field chooses round-robin, park core, park DMA or park current.
// - Register data shows externally only when show and external arbitration set.
// - Counter-width bit selects 16-bit or 24-bit DMA byte counters.
`timescale 1ns/100ps
`default_nettype none
module simwd_regs
  import simwd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire simwd_bus_t  bus,
  input  wire logic        pin_config_strap,
  input  wire logic        wd_timeout,
  input  wire logic        interrupt_ack_cycle,
  input  wire logic [2:0]  interrupt_level,
  input  wire logic        stop_request,
  output logic [15:0]      rdata,
  output logic [7:0]       interrupt_ack_cycle_vector,
  output logic             interrupt_ack_cycle_valid,
  output logic             watchdog_pending_bit,
  output logic             watchdog_service,
  output logic             stop_ack,
  output logic             core_clk_gated,
  output logic             core_wake,
  output logic [15:0]      pin_function_select,
  output simwd_park_t      park_mode,
  output logic             internal_arbitration_enable,
  output logic             external_arbitration_enable,
  output logic             register_data_show,
  output logic             counter_width_select
);

  simwd_state_t s_r;
  simwd_state_t s_nxt;
  logic         wake_hit;

  // Reset image of the whole state.
  // The pin select stays all zeros here because the strap is only caught after release.
  // Holding the image in one constant keeps the reset branch to a single assignment.
  localparam simwd_state_t SIMWD_RST_STATE = '{
    wd_vector:   SIMWD_RST_WD_VECTOR,
    park:        SIMWD_RST_PARK,
    stop_enable: 1'b0,
    svc:         SIMWD_SVC_IDLE,
    default:     '0
  };

  // Wake qualification against the programmed threshold.
  always_comb
  begin
    if (s_r.wake_threshold == SIMWD_WAKE_ANY)
      wake_hit = (interrupt_level != 3'h0);
    else if (s_r.wake_threshold == SIMWD_WAKE_NONE)
      wake_hit = 1'b0;
    else
      wake_hit = (interrupt_level > s_r.wake_threshold);
  end

  // Next-state logic for every register of the block.
  always_comb
  begin
    s_nxt               = s_r;
    s_nxt.service_pulse = 1'b0;
    s_nxt.stop_ack      = 1'b0;
    s_nxt.wake          = 1'b0;
    s_nxt.interrupt_ack_cycle_valid    = 1'b0;
    s_nxt.rst_seen      = 1'b1;
    // The strap is caught on the first clock after release, not in the reset branch.
    if (!s_r.rst_seen)
      s_nxt.pin_select = pin_config_strap ? SIMWD_PIN_ALL_ALT : SIMWD_PIN_ALL_PP;
    if (bus.wr)
    begin
      case (bus.addr)
        SIMWD_OFF_WD_VECTOR:  s_nxt.wd_vector = bus.wdata[7:0];
        SIMWD_OFF_PIN_SELECT: s_nxt.pin_select = bus.wdata;
        SIMWD_OFF_PARK:       s_nxt.park = bus.wdata[7:0] & SIMWD_PARK_MASK;
        SIMWD_OFF_CLK_CTRL:
        begin
          s_nxt.stop_enable    = bus.wdata[SIMWD_STOPEN_BIT];
          s_nxt.wake_threshold = bus.wdata[SIMWD_WAKE_HI:SIMWD_WAKE_LO];
        end
        SIMWD_OFF_WD_SERVICE:
        begin
          // Other values fall through untouched so an open sequence survives.
          if (bus.wdata[7:0] == SIMWD_KEY_FIRST)
            s_nxt.svc = SIMWD_SVC_ARMED;
          else if (bus.wdata[7:0] == SIMWD_KEY_SECOND && s_r.svc == SIMWD_SVC_ARMED)
          begin
            s_nxt.svc           = SIMWD_SVC_IDLE;
            s_nxt.service_pulse = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Read data; the vector register is write-only and reads zero.
    case (bus.addr)
      SIMWD_OFF_PIN_SELECT: s_nxt.rdata = s_r.pin_select;
      SIMWD_OFF_PARK:       s_nxt.rdata = {8'h00, s_r.park};
      SIMWD_OFF_CLK_CTRL:   s_nxt.rdata = {12'h000, s_r.stop_enable, s_r.wake_threshold};
      default:              s_nxt.rdata = 16'h0000;
    endcase
    if (!bus.rd)
      s_nxt.rdata = 16'h0000;
    // The show output is registered from the next park value so it leaves a flip-flop.
    // Showing internal data needs external arbitration too, else the bus would contend.
    s_nxt.show = s_nxt.park[SIMWD_SHOW_BIT] & s_nxt.park[SIMWD_EARB_BIT];
    // Acknowledge answers with the vector byte and cancels the pending flag.
    if (interrupt_ack_cycle && s_r.pending)
    begin
      s_nxt.interrupt_ack_cycle_vector = s_r.wd_vector;
      s_nxt.interrupt_ack_cycle_valid  = 1'b1;
      s_nxt.pending     = 1'b0;
    end
    // Timeout sets win over the acknowledge clear.
    if (wd_timeout)
      s_nxt.pending = 1'b1;
    // Stop is honoured only with stop enable set; only core clocks gate.
    if (stop_request && s_r.stop_enable && !s_r.core_clk_gated)
    begin
      s_nxt.stop_ack       = 1'b1;
      s_nxt.core_clk_gated = 1'b1;
    end
    if (s_r.core_clk_gated && wake_hit)
    begin
      s_nxt.core_clk_gated = 1'b0;
      s_nxt.wake           = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= SIMWD_RST_STATE;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from the state flip-flops.
  assign rdata                       = s_r.rdata;
  assign interrupt_ack_cycle_vector                 = s_r.interrupt_ack_cycle_vector;
  assign interrupt_ack_cycle_valid                  = s_r.interrupt_ack_cycle_valid;
  assign watchdog_pending_bit        = s_r.pending;
  assign watchdog_service            = s_r.service_pulse;
  assign stop_ack                    = s_r.stop_ack;
  assign core_clk_gated              = s_r.core_clk_gated;
  assign core_wake                   = s_r.wake;
  assign pin_function_select         = s_r.pin_select;
  assign park_mode                   = simwd_park_t'(s_r.park[SIMWD_PARK_HI:SIMWD_PARK_LO]);
  assign internal_arbitration_enable = s_r.park[SIMWD_IARB_BIT];
  assign external_arbitration_enable = s_r.park[SIMWD_EARB_BIT];
  // The gated show level was formed in the next-state logic.
  assign register_data_show          = s_r.show;
  assign counter_width_select        = s_r.park[SIMWD_WIDTH_BIT];

  // Assertions.
  // Reset checks look at the first edge after release, where the sampled state
  // still holds the reset image, so they need no disable clause.

  // The vector register must come out of reset with the uninitialised vector.
  // A wrong value here would hand software a random handler on the first timeout.
  reset_vector_a: assert property (
    @(posedge clock) $fell(rst) |-> s_r.wd_vector == SIMWD_RST_WD_VECTOR)
    else $error("Vector not at its reset value after reset.");

  // Stop enable must be clear after reset so that stop is refused at first.
  // Software has to opt in before the core can be put to sleep.
  reset_stop_a: assert property (
    @(posedge clock) $fell(rst) |-> !s_r.stop_enable)
    else $error("Stop enable set after reset.");

  // The park register must be all zeros after reset.
  // That selects round-robin with both arbitration enables off.
  reset_park_a: assert property (
    @(posedge clock) $fell(rst) |-> s_r.park == SIMWD_RST_PARK)
    else $error("Park register not zero after reset.");

  // The first edge after release copies the strap level into every pin select bit.
  // A register write in that same cycle wins, so it is left out of the antecedent.
  strap_load_a: assert property (
    @(posedge clock) disable iff (rst)
    !s_r.rst_seen && !(bus.wr && bus.addr == SIMWD_OFF_PIN_SELECT)
      |=> pin_function_select == ($past(pin_config_strap) ? SIMWD_PIN_ALL_ALT : SIMWD_PIN_ALL_PP))
    else $error("Pin select did not follow the strap.");

  // A pin select write lands on every bit of the output one cycle later.
  // Each bit picks the parallel port function when low, the alternate when high.
  pin_write_a: assert property (
    @(posedge clock) disable iff (rst)
    bus.wr && bus.addr == SIMWD_OFF_PIN_SELECT |=> pin_function_select == $past(bus.wdata))
    else $error("Pin select write did not land.");

  // Acknowledge with a pending flag returns the vector held at the request edge.
  // The vector is registered, so it stands in the cycle after the acknowledge.
  interrupt_ack_cycle_vector_a: assert property (
    @(posedge clock) disable iff (rst)
    interrupt_ack_cycle && s_r.pending |=> interrupt_ack_cycle_valid && interrupt_ack_cycle_vector == $past(s_r.wd_vector))
    else $error("Acknowledge did not return the vector.");

  // Every acknowledge answer carries the programmed byte, never a fixed autovector.
  // Compared against the value the register held when the answer was formed.
  no_autovec_a: assert property (
    @(posedge clock) disable iff (rst)
    interrupt_ack_cycle_valid |-> interrupt_ack_cycle_vector == $past(s_r.wd_vector))
    else $error("Acknowledge vector differs from programmed value.");

  // A service pulse follows only a write of the second key.
  // The first key alone must never restart the watchdog counter.
  svc_pair_a: assert property (
    @(posedge clock) disable iff (rst)
    watchdog_service |-> $past(bus.wr && bus.addr == SIMWD_OFF_WD_SERVICE
      && bus.wdata[7:0] == SIMWD_KEY_SECOND))
    else $error("Service without the second key.");

  // An armed sequence survives any access that is not to the service register.
  // Software may run arbitrary code between the two key writes.
  svc_hold_a: assert property (
    @(posedge clock) disable iff (rst)
    s_r.svc == SIMWD_SVC_ARMED && !(bus.wr && bus.addr == SIMWD_OFF_WD_SERVICE)
      |=> s_r.svc == SIMWD_SVC_ARMED)
    else $error("Service sequence aborted.");

  // A service write with any other value leaves the sequence state alone.
  // It also must not produce a service pulse, so the count is untouched.
  svc_other_a: assert property (
    @(posedge clock) disable iff (rst)
    bus.wr && bus.addr == SIMWD_OFF_WD_SERVICE && bus.wdata[7:0] != SIMWD_KEY_FIRST
      && bus.wdata[7:0] != SIMWD_KEY_SECOND |=> s_r.svc == $past(s_r.svc) && !watchdog_service)
    else $error("Stray service value changed the sequence.");

  // A timeout always raises the pending flag on the next edge.
  // It beats an acknowledge falling in the same cycle.
  pend_set_a: assert property (
    @(posedge clock) disable iff (rst)
    wd_timeout |=> watchdog_pending_bit)
    else $error("Timeout did not raise pending.");

  // Once pending, only an acknowledge may drop the flag.
  // Service writes after the timeout are too late to cancel it.
  pend_keep_a: assert property (
    @(posedge clock) disable iff (rst)
    watchdog_pending_bit && !interrupt_ack_cycle |=> watchdog_pending_bit)
    else $error("Pending flag lost without acknowledge.");

  // The acknowledge cycle clears the flag by itself.
  // Software needs no extra write to cancel the interrupt.
  pend_clear_a: assert property (
    @(posedge clock) disable iff (rst)
    interrupt_ack_cycle && !wd_timeout |=> !watchdog_pending_bit)
    else $error("Acknowledge did not clear pending.");

  // A stop acknowledge only ever follows an edge with stop enable set.
  // This is the gate that keeps low-power modes off until software allows them.
  stop_gate_a: assert property (
    @(posedge clock) disable iff (rst)
    stop_ack |-> $past(s_r.stop_enable))
    else $error("Stop acknowledged while disabled.");

  // A stop request with stop enable clear is refused outright.
  // The core keeps its clocks and sees no acknowledge.
  stop_refuse_a: assert property (
    @(posedge clock) disable iff (rst)
    stop_request && !s_r.stop_enable && !core_clk_gated |=> !stop_ack && !core_clk_gated)
    else $error("Stop honoured without stop enable.");

  // With stop enable set a stop request gates the core clocks on the next edge.
  // A request while already gated is ignored, since the core cannot issue it.
  stop_honour_a: assert property (
    @(posedge clock) disable iff (rst)
    stop_request && s_r.stop_enable && !core_clk_gated |=> stop_ack && core_clk_gated)
    else $error("Stop not honoured with stop enable set.");

  // While the core is stopped the rest of the block keeps running.
  // A timeout must still raise the flag that will later wake the core.
  others_run_a: assert property (
    @(posedge clock) disable iff (rst)
    core_clk_gated && wd_timeout |=> watchdog_pending_bit)
    else $error("Timeout lost while core clocks were stopped.");

  // Threshold code 111 never lets a level through.
  wake_none_a: assert property (
    @(posedge clock) disable iff (rst)
    s_r.wake_threshold == SIMWD_WAKE_NONE |-> !wake_hit)
    else $error("Wake with the no-wake threshold.");

  // Threshold code 000 lets any nonzero level wake a stopped core.
  // Level zero means no interrupt at all and must not count.
  wake_any_a: assert property (
    @(posedge clock) disable iff (rst)
    core_clk_gated && s_r.wake_threshold == SIMWD_WAKE_ANY && interrupt_level != 3'h0
      |=> core_wake && !core_clk_gated)
    else $error("Any-level threshold did not wake the core.");

  // A qualifying level restores core clocks and signals the wake together.
  // Both show on the same edge, so exception processing sees running clocks.
  wake_restore_a: assert property (
    @(posedge clock) disable iff (rst)
    core_clk_gated && wake_hit |=> !core_clk_gated && core_wake)
    else $error("Qualifying level did not restore core clocks.");

  // A park write lands with its reserved bits forced low.
  // Reads then never return stale values in bits 2 and 1.
  park_write_a: assert property (
    @(posedge clock) disable iff (rst)
    bus.wr && bus.addr == SIMWD_OFF_PARK |=> s_r.park == ($past(bus.wdata[7:0]) & SIMWD_PARK_MASK))
    else $error("Park write did not land.");

  // The arbitration mode output follows the written park field.
  park_field_a: assert property (
    @(posedge clock) disable iff (rst)
    bus.wr && bus.addr == SIMWD_OFF_PARK
      |=> park_mode == simwd_park_t'($past(bus.wdata[SIMWD_PARK_HI:SIMWD_PARK_LO])))
    else $error("Park mode does not follow the park field.");

  // The counter width output follows the written width bit.
  // Low selects 16-bit DMA byte counters, high selects 24-bit ones.
  width_bit_a: assert property (
    @(posedge clock) disable iff (rst)
    bus.wr && bus.addr == SIMWD_OFF_PARK |=> counter_width_select == $past(bus.wdata[SIMWD_WIDTH_BIT]))
    else $error("Counter width does not follow the width bit.");

  // Internal data may only be shown while external arbitration is enabled.
  show_gate_a: assert property (
    @(posedge clock) disable iff (rst)
    register_data_show |-> external_arbitration_enable)
    else $error("Show data without external arbitration.");

  // Main scenarios that a run should reach.
  svc_cov_c:  cover property (@(posedge clock) watchdog_service);
  interrupt_ack_cycle_cov_c: cover property (@(posedge clock) interrupt_ack_cycle_valid);
  stop_cov_c: cover property (@(posedge clock) stop_ack);
  wake_cov_c: cover property (@(posedge clock) core_wake);
  show_cov_c: cover property (@(posedge clock) register_data_show);

endmodule : simwd_regs
`default_nettype wire

// File: tb/simwd_core.sv
// Core processor model that issues register, stop and acknowledge requests.
`timescale 1ns/100ps
`default_nettype none
module simwd_core
  import simwd_pkg::*;
(
  input  wire logic        clock,
  output simwd_bus_t       bus,
  output logic             stop_request,
  output logic             interrupt_ack_cycle,
  input  wire logic [15:0] rdata
);
  // Idle at time zero; every request starts just after a falling edge.
  initial
  begin
    bus = '0;
    stop_request = 1'b0;
    interrupt_ack_cycle = 1'b0;
  end
  // Released lines show the inverse, so a stale value is never mistaken for data.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  // Read data stands one cycle after the request edge.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock);
    bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~bus.wdata};
    @(negedge clock);
    d = rdata;
    bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~bus.wdata};
  endtask : rd
  // One-cycle stop instruction request.
  task automatic stop();
    @(negedge clock);
    stop_request = 1'b1;
    @(negedge clock);
    stop_request = 1'b0;
  endtask : stop
  // One-cycle watchdog acknowledge cycle.
  task automatic ack();
    @(negedge clock);
    interrupt_ack_cycle = 1'b1;
    @(negedge clock);
    interrupt_ack_cycle = 1'b0;
  endtask : ack
endmodule : simwd_core
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the watchdog, stop, pin select and park registers.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
  import simwd_pkg::*;
  logic clock, rst, pin_config_strap, wd_timeout, stop_request, interrupt_ack_cycle;
  logic [2:0] interrupt_level;
  simwd_bus_t bus;
  logic [15:0] rdata, pin_function_select, d;
  logic [7:0] interrupt_ack_cycle_vector;
  logic interrupt_ack_cycle_valid, watchdog_pending_bit, watchdog_service, stop_ack, core_clk_gated, core_wake;
  simwd_park_t park_mode;
  logic internal_arbitration_enable, external_arbitration_enable;
  logic register_data_show, counter_width_select, g, w;
  int error_cnt, total_checks, cyc;
  simwd_regs simwd_regs_i (.clock, .rst, .bus, .pin_config_strap, .wd_timeout,
    .interrupt_ack_cycle, .interrupt_level, .stop_request, .rdata, .interrupt_ack_cycle_vector, .interrupt_ack_cycle_valid,
    .watchdog_pending_bit, .watchdog_service, .stop_ack, .core_clk_gated, .core_wake,
    .pin_function_select, .park_mode, .internal_arbitration_enable,
    .external_arbitration_enable, .register_data_show, .counter_width_select);
  simwd_core simwd_core_i (.clock, .bus, .stop_request, .interrupt_ack_cycle, .rdata);
  // Free-running 250 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Cycle ceiling cuts a hang short and counts it as a mismatch.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // Reset with a given strap level, then check the pin select, park, stop enable and vector reset values.
  task automatic t_reset(input logic s);
    @(negedge clock);
    rst = 1'b1;
    pin_config_strap = s;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    `CHK(pin_function_select, {16{s}})
    simwd_core_i.rd(SIMWD_OFF_PARK, d);
    `CHK(d, 16'h0000)
    simwd_core_i.stop();
    `CHK(stop_ack, 1'b0)
    `CHK(core_clk_gated, 1'b0)
    t_ack(8'h0F);
  endtask : t_reset
  // Raise a timeout, then acknowledge it and expect the programmed vector.
  task automatic t_ack(input logic [7:0] v);
    @(negedge clock);
    wd_timeout = 1'b1;
    @(negedge clock);
    wd_timeout = 1'b0;
    `CHK(watchdog_pending_bit, 1'b1)
    simwd_core_i.ack();
    `CHK(interrupt_ack_cycle_valid, 1'b1)
    `CHK(interrupt_ack_cycle_vector, v)
    `CHK(watchdog_pending_bit, 1'b0)
  endtask : t_ack
  // Stray keys, interleaved accesses and a late service around a timeout.
  task automatic t_service();
    simwd_core_i.wr(SIMWD_OFF_WD_SERVICE, 16'h00AA);
    `CHK(watchdog_service, 1'b0)
    simwd_core_i.wr(SIMWD_OFF_WD_SERVICE, 16'h0055);
    simwd_core_i.wr(SIMWD_OFF_WD_SERVICE, 16'h0012);
    simwd_core_i.rd(SIMWD_OFF_PARK, d);
    simwd_core_i.wr(SIMWD_OFF_WD_SERVICE, 16'h00AA);
    `CHK(watchdog_service, 1'b1)
    @(negedge clock);
    `CHK(watchdog_service, 1'b0)
    simwd_core_i.wr(SIMWD_OFF_WD_VECTOR, 16'h005A);
    @(negedge clock);
    wd_timeout = 1'b1;
    @(negedge clock);
    wd_timeout = 1'b0;
    simwd_core_i.wr(SIMWD_OFF_WD_SERVICE, 16'h0055);
    simwd_core_i.wr(SIMWD_OFF_WD_SERVICE, 16'h00AA);
    `CHK(watchdog_pending_bit, 1'b1)
    simwd_core_i.ack();
    `CHK(interrupt_ack_cycle_vector, 8'h5A)
  endtask : t_service
  // Pin select and every park code, with the show bit gated by external arbitration.
  task automatic t_regs();
    simwd_core_i.wr(SIMWD_OFF_PIN_SELECT, 16'hA5C3);
    simwd_core_i.rd(SIMWD_OFF_PIN_SELECT, d);
    `CHK(d, 16'hA5C3)
    `CHK(pin_function_select, 16'hA5C3)
    for (int p = 0; p < 4; p++)
    begin
      simwd_core_i.wr(SIMWD_OFF_PARK, 16'(p * 64 + 63));
      simwd_core_i.rd(SIMWD_OFF_PARK, d);
      `CHK(d, 16'(p * 64 + 57))
      `CHK(park_mode, simwd_park_t'(p))
      `CHK({internal_arbitration_enable, external_arbitration_enable}, 2'h3)
      `CHK({register_data_show, counter_width_select}, 2'h3)
    end
    simwd_core_i.wr(SIMWD_OFF_PARK, 16'h0008);
    `CHK({register_data_show, counter_width_select}, 2'h0)
  endtask : t_regs
  // Each wake threshold against every nonzero level while the core clocks are stopped.
  task automatic t_stop();
    for (int t = 0; t < 8; t++)
    begin
      simwd_core_i.wr(SIMWD_OFF_CLK_CTRL, 16'(8 + t));
      simwd_core_i.stop();
      `CHK({stop_ack, core_clk_gated}, 2'h3)
      g = 1'b1;
      for (int l = 1; l < 8; l++)
      begin
        interrupt_level = 3'(l);
        @(negedge clock);
        w = g && (l > t) && (t != 7);
        `CHK(core_wake, w)
        g = g && !w;
        `CHK(core_clk_gated, g)
      end
      interrupt_level = 3'h0;
    end
    t_ack(8'h5A);
    `CHK(core_clk_gated, 1'b1)
    simwd_core_i.wr(SIMWD_OFF_PARK, 16'h0040);
    `CHK(park_mode, SIMWD_PARK_CORE)
  endtask : t_stop
  // Main sequence; the second reset lands in mid-run with core clocks gated.
  initial
  begin
    rst = 1'b1;
    pin_config_strap = 1'b1;
    wd_timeout = 1'b0;
    interrupt_level = 3'h0;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    t_reset(1'b1);
    t_service();
    t_regs();
    t_stop();
    t_reset(1'b0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
